/* File: logic/tap_map.svh */
// Constants for the boundary-scan test port: instruction codes, capture
// pattern, tester sequencing counts and link timing.
// Assumes inclusion by bare name from the package and both ends.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// Instruction register width and its fixed capture value
`define IR_W 4
`define IR_CAPTURE 4'h1

// Public instruction codes
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h3
`define IR_CLAMP 4'h5
`define IR_HIGHZ 4'h7
`define IR_CLAMPZ 4'h9
`define IR_INTEST 4'hc
`define IR_IDCODE 4'he
`define IR_BYPASS 4'hf

// Identification register width
`define ID_W 32

// Tester timing: system clock period and test clock period in ns
`define MCLK_PERIOD_NS 10
`define TCK_PERIOD_NS 120

// Tester sequencing: test-reset low periods, then high-TMS periods
`define RST_LOW_STEPS 8'h02
`define RST_ONE_STEPS 8'h05

// TMS patterns from Run-Test/Idle to Shift-IR or Shift-DR (bit i = step i)
`define HEAD_IR 4'h3
`define HEAD_IR_LAST 8'h03
`define HEAD_DR 4'h1
`define HEAD_DR_LAST 8'h02

`endif

/* File: logic/tap_pkg.sv */
// Types shared by the two ends of the test link.
// Assumes tap_map.svh is on the include path.
`include "tap_map.svh"

package tap_pkg;

  // TAP controller states
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHF_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PAU_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hc,
    ST_SEL_IR = 4'hd,
    ST_CAP_IR = 4'hf,
    ST_SHF_IR = 4'he,
    ST_EX1_IR = 4'ha,
    ST_PAU_IR = 4'hb,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_t;

  // Instruction register contents
  typedef logic [`IR_W-1:0] ir_code_t;

  // Serial path selected between data in and data out
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_ID = 2'h1,
    PATH_BS = 2'h3
  } dr_path_t;

  // Tester command kinds
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0,
    CMD_IR = 2'h1,
    CMD_DR = 2'h2
  } cmd_kind_t;

  // Tester sequencer states
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0,
    TS_RST = 3'h1,
    TS_HEAD = 3'h3,
    TS_SHIFT = 3'h2,
    TS_TAIL = 3'h6,
    TS_LAST = 3'h7
  } tst_state_t;

endpackage

/* File: logic/tap_if.sv */
// Five-wire test link between the tester and the device test port.
// Assumes the tester makes the test clock; the bench joins both modports.
`timescale 1ns/1ns
`default_nettype none

interface tap_if;
  logic tck; // Test clock, made by tester
  logic tms; // Mode select
  logic tdi; // Serial data to device
  logic trst_n; // Async test reset, active low
  logic tdo; // Serial data from device
  logic tdo_oe; // Device drives tdo while high

  // Documented device end
  modport dev (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
  // Tester end
  modport tst (output tck, output tms, output tdi, output trst_n, input tdo, input tdo_oe);
endinterface

`default_nettype wire

/* File: logic/tap_device.sv */
// Device test port: TAP controller, instruction, bypass, identification
// and boundary registers, plus the boundary cells between core and pads.
// Assumes the link clock runs only when the tester drives it; all test
// logic runs on it and resets asynchronously from the test reset.
`timescale 1ns/1ns
`default_nettype none
`include "tap_map.svh"

module tap_device
  import tap_pkg::*;
#(
  parameter int N_IN = 8, // Input pad cells
  parameter int N_OUT = 8, // Output pad cells
  parameter logic [`ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
  tap_if.dev link, // Test link
  input wire logic [N_IN-1:0] pin_in_i, // From input pads
  output logic [N_IN-1:0] core_in_o, // To core logic
  input wire logic [N_OUT-1:0] core_out_i, // From core logic
  input wire logic core_oe_i, // Core output enable
  output logic [N_OUT-1:0] pin_out_o, // To output pads
  output logic pin_oe_o // Output pad enable
);
  import tap_pkg::*;

  localparam int BS_W = N_IN + N_OUT + 1; // Inputs, outputs, enable cell

  tap_state_t st_r; // Controller state
  tap_state_t st_nxt; // Next controller state
  ir_code_t ir_shf_r; // Instruction shift stage
  ir_code_t ir_r; // Current instruction
  logic byp_r; // Bypass bit
  logic [`ID_W-1:0] id_r; // Identification shift register
  logic [BS_W-1:0] bs_shf_r; // Boundary shift stage
  logic [BS_W-1:0] bs_upd_r; // Boundary output latch
  logic [BS_W-1:0] smp_a_r; // Cell sample, first stage
  logic [BS_W-1:0] smp_b_r; // Cell sample, second stage
  logic tdo_r; // Registered serial out
  logic tdo_oe_r; // Serial out enable

  // Instruction decode, used for path and for cell modes
  function automatic dr_path_t path_of(input ir_code_t c);
    case (c)
      `IR_EXTEST, `IR_SAMPLE, `IR_INTEST: path_of = PATH_BS;
      `IR_IDCODE: path_of = PATH_ID;
      default: path_of = PATH_BYPASS; // Clamps, bypass, unknown codes
    endcase
  endfunction

  wire dr_path_t path = path_of(ir_r);
  wire test_mode = (ir_r == `IR_EXTEST) || (ir_r == `IR_INTEST);
  wire intest = (ir_r == `IR_INTEST);
  wire extest = (ir_r == `IR_EXTEST);
  wire clamp = (ir_r == `IR_CLAMP);
  wire highz = (ir_r == `IR_HIGHZ);
  wire clampz = (ir_r == `IR_CLAMPZ);

  // Boundary latch fields
  wire [N_IN-1:0] upd_in = bs_upd_r[N_IN-1:0];
  wire [N_OUT-1:0] upd_out = bs_upd_r[N_IN+N_OUT-1:N_IN];
  wire upd_oe = bs_upd_r[BS_W-1];

  // Pad paths: system mode straight through, test mode from the latch
  // Sample/preload is not a test mode, so its updates stay hidden
  assign core_in_o = test_mode ? upd_in : pin_in_i;
  assign pin_out_o = (test_mode || clamp || clampz) ? upd_out : core_out_i;
  assign pin_oe_o = (highz || clampz) ? 1'b0 :
                    (test_mode || clamp) ? upd_oe : core_oe_i;

  // Cell views: pads with latch-driven outputs, core side, plain system
  wire [BS_W-1:0] cell_ext = {pin_oe_o, pin_out_o, pin_in_i};
  wire [BS_W-1:0] cell_int = {core_oe_i, core_out_i, core_in_o};
  wire [BS_W-1:0] cell_sys = {core_oe_i, core_out_i, pin_in_i};

  // Snapshot source per instruction; external test sees pads and latch
  wire [BS_W-1:0] smp_raw = intest ? cell_int :
                            extest ? cell_ext : cell_sys;
  wire [BS_W-1:0] cap_val = intest ?
    {smp_b_r[BS_W-1:N_IN], ~smp_b_r[N_IN-1:0]} : smp_b_r;

  // Controller next state, steered by TMS
  always_comb begin
    case (st_r)
      ST_TLR: st_nxt = link.tms ? ST_TLR : ST_RTI;
      ST_RTI: st_nxt = link.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: st_nxt = link.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = link.tms ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: st_nxt = link.tms ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: st_nxt = link.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_nxt = link.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_nxt = link.tms ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: st_nxt = link.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: st_nxt = link.tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: st_nxt = link.tms ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: st_nxt = link.tms ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: st_nxt = link.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_nxt = link.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_nxt = link.tms ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: st_nxt = link.tms ? ST_SEL_DR : ST_RTI;
      default: st_nxt = ST_TLR;
    endcase
  end

  // Controller state, reset without any clock edge
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      st_r <= ST_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Instruction register; reset and Test-Logic-Reset pick identification
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_shf_r <= `IR_CAPTURE;
      ir_r <= `IR_IDCODE;
    end else begin
      case (st_r)
        ST_TLR: ir_r <= `IR_IDCODE;
        ST_CAP_IR: ir_shf_r <= `IR_CAPTURE;
        ST_SHF_IR: ir_shf_r <= {link.tdi, ir_shf_r[`IR_W-1:1]};
        ST_UPD_IR: ir_r <= ir_shf_r;
        default: ir_r <= ir_r; // Hold
      endcase
    end
  end

  // Bypass and identification registers
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      byp_r <= 1'b0;
      id_r <= '0;
    end else begin
      if (st_r == ST_CAP_DR) begin
        byp_r <= 1'b0;
        id_r <= ID_CODE;
      end else if (st_r == ST_SHF_DR) begin
        if (path == PATH_BYPASS) begin
          byp_r <= link.tdi;
        end
        if (path == PATH_ID) begin
          id_r <= {link.tdi, id_r[`ID_W-1:1]};
        end
      end
    end
  end

  // Cell sampler: pad and core values cross into the link domain
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      smp_a_r <= '0;
      smp_b_r <= '0;
    end else begin
      smp_a_r <= smp_raw;
      smp_b_r <= smp_a_r;
    end
  end

  // Boundary register: capture, shift, update only when it is the path
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bs_shf_r <= '0;
      bs_upd_r <= '0;
    end else if (path == PATH_BS) begin
      case (st_r)
        ST_CAP_DR: bs_shf_r <= cap_val;
        ST_SHF_DR: bs_shf_r <= {link.tdi, bs_shf_r[BS_W-1:1]};
        ST_UPD_DR: bs_upd_r <= bs_shf_r;
        default: bs_upd_r <= bs_upd_r; // Hold
      endcase
    end
  end

  // Serial out selection for the current shift state
  wire tdo_dr = (path == PATH_BS) ? bs_shf_r[0] :
                (path == PATH_ID) ? id_r[0] : byp_r;
  wire shifting = (st_r == ST_SHF_DR) || (st_r == ST_SHF_IR);
  wire tdo_sel = (st_r == ST_SHF_IR) ? ir_shf_r[0] : tdo_dr;

  // Serial out changes on the falling edge, and clears at once on test reset
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= shifting ? tdo_sel : 1'b0;
      tdo_oe_r <= shifting;
    end
  end

  assign link.tdo = tdo_r;
  assign link.tdo_oe = tdo_oe_r;

endmodule

`default_nettype wire

/* File: logic/tap_tester.sv */
// Tester end: makes the test clock by dividing its own clock, walks the
// controller through reset, instruction scans and data scans.
// Assumes one command at a time; data shifts least significant bit first.
`timescale 1ns/1ns
`default_nettype none
`include "tap_map.svh"

module tap_tester
  import tap_pkg::*;
#(
  parameter int MAXLEN = 64, // Longest scan in bits
  parameter int HALF = `TCK_PERIOD_NS / (2 * `MCLK_PERIOD_NS) // Cycles per half period
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  tap_if.tst link, // Test link
  input wire logic cmd_valid_i, // Command offered
  output logic cmd_ready_o, // Command taken when high
  input wire tap_pkg::cmd_kind_t cmd_kind_i, // Reset, IR or DR scan
  input wire logic [7:0] cmd_len_i, // Scan length, 1..MAXLEN
  input wire logic [MAXLEN-1:0] cmd_data_i, // Bits to shift in
  output logic rsp_valid_o, // Command done pulse
  output logic [MAXLEN-1:0] rsp_data_o // Bits shifted out
);
  import tap_pkg::*;

  tst_state_t st_r; // Sequencer state
  cmd_kind_t kind_r; // Command in progress
  logic [7:0] len_r; // Scan length
  logic [7:0] step_r; // Step within state
  logic [15:0] cnt_r; // Half-period counter
  logic tck_r; // Test clock out
  logic tms_r; // Mode select out
  logic tdi_r; // Serial data out
  logic trst_n_r; // Test reset out
  logic [MAXLEN-1:0] tx_r; // Bits still to send
  logic [MAXLEN-1:0] rx_r; // Bits received
  logic [MAXLEN-1:0] rsp_r; // Answer
  logic rsp_v_r; // Answer pulse
  logic tdo_a_r; // Serial in, first stage
  logic tdo_b_r; // Serial in, second stage

  // Step bookkeeping
  wire is_ir = (kind_r == CMD_IR);
  wire [7:0] head_last = is_ir ? `HEAD_IR_LAST : `HEAD_DR_LAST;
  wire [3:0] head_pat = is_ir ? `HEAD_IR : `HEAD_DR;
  wire [7:0] rst_last = `RST_LOW_STEPS + `RST_ONE_STEPS;
  wire half_end = (cnt_r == 16'(HALF - 1));
  wire rise = half_end && !tck_r;
  wire fall = half_end && tck_r;

  // Link outputs for the present step, latched at the falling edge
  wire tms_w = (st_r == TS_RST) ? (step_r < rst_last) :
               (st_r == TS_HEAD) ? head_pat[step_r[1:0]] :
               (st_r == TS_SHIFT) ? (step_r == len_r - 8'h01) :
               (st_r == TS_TAIL) ? (step_r == 8'h00) : 1'b0;
  wire trst_w = !((st_r == TS_RST) && (step_r < `RST_LOW_STEPS));
  wire tdi_w = (st_r == TS_SHIFT) ? tx_r[0] : 1'b0;
  wire [7:0] dshift = 8'(MAXLEN) - len_r;

  assign cmd_ready_o = (st_r == TS_IDLE);

  // Serial in from the device crosses into the system domain
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_a_r <= 1'b0;
      tdo_b_r <= 1'b0;
    end else begin
      tdo_a_r <= link.tdo;
      tdo_b_r <= tdo_a_r;
    end
  end

  // Sequencer: divide clock, step at rising, drive at falling edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= TS_IDLE;
      kind_r <= CMD_RESET;
      len_r <= 8'h00;
      step_r <= 8'h00;
      cnt_r <= 16'h0000;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b0;
      trst_n_r <= 1'b1;
      tx_r <= '0;
      rx_r <= '0;
      rsp_r <= '0;
      rsp_v_r <= 1'b0;
    end else begin
      rsp_v_r <= 1'b0;
      if (st_r == TS_IDLE) begin
        cnt_r <= 16'h0000;
        tck_r <= 1'b0;
        if (cmd_valid_i) begin
          kind_r <= cmd_kind_i;
          len_r <= cmd_len_i;
          tx_r <= cmd_data_i;
          step_r <= 8'h00;
          tms_r <= 1'b1;
          tdi_r <= 1'b0;
          trst_n_r <= (cmd_kind_i != CMD_RESET);
          st_r <= (cmd_kind_i == CMD_RESET) ? TS_RST : TS_HEAD;
        end
      end else begin
        cnt_r <= half_end ? 16'h0000 : cnt_r + 16'h0001;
        if (half_end) begin
          tck_r <= ~tck_r;
        end
        if (fall) begin
          tms_r <= tms_w;
          tdi_r <= tdi_w;
          trst_n_r <= trst_w;
          if (st_r == TS_LAST) begin
            st_r <= TS_IDLE;
            rsp_v_r <= 1'b1;
            rsp_r <= rx_r >> dshift;
          end
        end
        if (rise) begin
          step_r <= step_r + 8'h01;
          case (st_r)
            TS_RST: if (step_r == rst_last) begin
              st_r <= TS_LAST;
            end
            TS_HEAD: if (step_r == head_last) begin
              st_r <= TS_SHIFT;
              step_r <= 8'h00;
            end
            TS_SHIFT: begin
              rx_r <= {tdo_b_r, rx_r[MAXLEN-1:1]};
              tx_r <= tx_r >> 1;
              if (step_r == len_r - 8'h01) begin
                st_r <= TS_TAIL;
                step_r <= 8'h00;
              end
            end
            TS_TAIL: if (step_r == 8'h01) begin
              st_r <= TS_LAST;
            end
            default: st_r <= st_r; // Last waits for fall
          endcase
        end
      end
    end
  end

  assign link.tck = tck_r;
  assign link.tms = tms_r;
  assign link.tdi = tdi_r;
  assign link.trst_n = trst_n_r;
  assign rsp_valid_o = rsp_v_r;
  assign rsp_data_o = rsp_r;

endmodule

`default_nettype wire

/* File: bench/tap_assertions.sv */
// Checker for the five-wire test link, fed with the link signals.
// Assumes instantiation in the bench beside the interface.
`timescale 1ns/1ns
`default_nettype none
`include "tap_map.svh"
module tap_assertions
  import tap_pkg::*;
#(
  parameter logic [`ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
  input wire logic tck, // Test clock
  input wire logic tms, // Mode select
  input wire logic tdi, // Serial in
  input wire logic trst_n, // Test reset, active low
  input wire logic tdo, // Serial out
  input wire logic tdo_oe // Serial out enable
);
  localparam ir_code_t CAP_V = `IR_CAPTURE; // Capture pattern
  tap_state_t st_r, st_nxt; // Reference controller
  ir_code_t ir_r, irs_r; // Reference instruction and shift stage
  logic [7:0] cnt_r; // Rises since capture
  // Standard controller steering
  always_comb begin
    case (st_r)
      ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI: st_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: st_nxt = tms ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: st_nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: st_nxt = tms ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SHF_IR;
      default: st_nxt = tms ? ST_SEL_DR : ST_RTI;
    endcase
  end
  // Reference state, instruction and bit count
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st_r <= ST_TLR;
      ir_r <= `IR_IDCODE;
      irs_r <= `IR_IDCODE;
      cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_r == ST_CAP_DR || st_r == ST_CAP_IR) ? 8'h00 : cnt_r + 8'h01;
      irs_r <= (st_r == ST_SHF_IR) ? {tdi, irs_r[3:1]} : irs_r;
      ir_r <= (st_r == ST_UPD_IR) ? irs_r : (st_r == ST_TLR) ? `IR_IDCODE : ir_r;
    end
  end
  wire logic shf = (st_r == ST_SHF_DR) || (st_r == ST_SHF_IR); // Shifting
  wire logic is_id = ir_r == `IR_IDCODE; // Ident path
  wire logic is_bs = ir_r == `IR_EXTEST || ir_r == `IR_SAMPLE || ir_r == `IR_INTEST;
  wire logic is_byp = !is_id && !is_bs; // Bypass path
  default clocking cb @(posedge tck); endclocking
  default disable iff (!trst_n);
  sequence s_byp;
    st_r == ST_SHF_DR && is_byp ##1 st_r == ST_SHF_DR;
  endsequence
  sequence s_five;
    tms [*5];
  endsequence
  AST_RESET_QUIET: assert property (!$past(trst_n) |-> !tdo_oe && !tdo)
    else $error("serial out active after test reset");
  AST_OE_SHIFT: assert property (tdo_oe == shf)
    else $error("serial out enable not tied to shift states");
  AST_TDO_IDLE: assert property (!tdo_oe |-> !tdo)
    else $error("serial out not low outside shift");
  AST_IR_CAPTURE: assert property (st_r == ST_SHF_IR && cnt_r < 8'h04 |-> tdo == CAP_V[cnt_r[1:0]])
    else $error("instruction capture pattern wrong");
  AST_ID_SHIFT: assert property (st_r == ST_SHF_DR && is_id && cnt_r < 8'h20 |-> tdo == ID_CODE[cnt_r[4:0]])
    else $error("identification bit wrong");
  AST_BYP_FIRST: assert property (st_r == ST_SHF_DR && is_byp && cnt_r == 8'h00 |-> !tdo)
    else $error("bypass first bit not zero");
  AST_BYP_DELAY: assert property (s_byp |-> tdo == $past(tdi))
    else $error("bypass delay not one clock");
  AST_TLR_FIVE: assert property (s_five |=> !tdo_oe)
    else $error("five high mode samples left a shift state");
endmodule
`default_nettype wire

/* File: bench/boundary_scan_tap_tb.sv */
// Bench joining tester and device ends over the link, with the checker.
// Assumes the tester makes the test clock from the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "tap_map.svh"
module boundary_scan_tap_tb;
  import tap_pkg::*;
  localparam logic [31:0] ID = 32'h3c5a_9e01; // Arbitrary value
  logic mclk_i, rst_n_i, valid, ready, rsp_valid, core_oe, pin_oe; // Ports
  cmd_kind_t kind; // Command kind
  logic [7:0] len, pin_in, core_in, core_out, pin_out; // Length, pads
  logic [63:0] data, rsp, p, q, d; // Scan data
  logic [63:0] exp_q[$], msk_q[$]; // Expected answers
  int mismatches, n_compared; // Counts
  ir_code_t all_c[8] = '{`IR_EXTEST, `IR_SAMPLE, `IR_CLAMP, `IR_HIGHZ,
    `IR_CLAMPZ, `IR_INTEST, `IR_IDCODE, `IR_BYPASS};
  ir_code_t byp_c[5] = '{`IR_CLAMP, `IR_HIGHZ, `IR_CLAMPZ, `IR_BYPASS, 4'h2};
  tap_if tap_if_i ();
  tap_device #(.N_IN(8), .N_OUT(8), .ID_CODE(ID)) tap_device_i (.link(tap_if_i),
    .pin_in_i(pin_in), .core_in_o(core_in), .core_out_i(core_out),
    .core_oe_i(core_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  tap_tester #(.MAXLEN(64)) tap_tester_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .link(tap_if_i), .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_kind_i(kind),
    .cmd_len_i(len), .cmd_data_i(data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp));
  tap_assertions #(.ID_CODE(ID)) tap_assertions_i (.tck(tap_if_i.tck),
    .tms(tap_if_i.tms), .tdi(tap_if_i.tdi), .trst_n(tap_if_i.trst_n),
    .tdo(tap_if_i.tdo), .tdo_oe(tap_if_i.tdo_oe));
  // System clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Note the answer, offer the command, wait for its answer
  task automatic cmd(input cmd_kind_t k, input logic [7:0] n, input logic [63:0] v,
                     input logic [63:0] e);
    logic [63:0] m;
    m = (k == CMD_RESET) ? 64'h0 : (64'h1 << n) - 64'h1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge mclk_i);
    kind <= k;
    len <= n;
    data <= v;
    valid <= 1'b1;
    do @(posedge mclk_i); while (ready !== 1'b1);
    valid <= 1'b0;
    do @(posedge mclk_i); while (rsp_valid !== 1'b1);
    @(negedge mclk_i);
  endtask
  // Pads and core straight through
  task automatic sys();
    check(64'({core_in, pin_out, pin_oe}), 64'({pin_in, core_out, core_oe}));
  endtask
  // Cells drive core and pads from the latch
  task automatic lat(input logic [63:0] v);
    check(64'({pin_oe, pin_out, core_in}), 64'(v[16:0]));
  endtask
  // Answer watcher
  always @(posedge mclk_i) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR %0t answer with no expectation", $time);
      end else begin
        check(rsp & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end
  // Hang guard, about ten times the expected run
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    d = 64'($urandom(32'h67f4));
    valid = 1'b0;
    kind = CMD_RESET;
    {len, data, rst_n_i} = '0;
    {pin_in, core_out, core_oe} = 17'($urandom());
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cmd(CMD_RESET, 8'h00, 64'h0, 64'h0);
    sys();
    cmd(CMD_DR, 8'h20, 64'($urandom()), 64'(ID));
    foreach (all_c[i]) cmd(CMD_IR, 8'h04, 64'(all_c[i]), 64'(`IR_CAPTURE));
    @(posedge mclk_i);
    {pin_in, core_out, core_oe} <= 17'($urandom());
    p = 64'(17'($urandom()));
    q = 64'(17'($urandom()));
    cmd(CMD_IR, 8'h04, 64'(`IR_SAMPLE), 64'(`IR_CAPTURE));
    cmd(CMD_DR, 8'h11, p, 64'({core_oe, core_out, pin_in}));
    sys();
    cmd(CMD_IR, 8'h04, 64'(`IR_EXTEST), 64'(`IR_CAPTURE));
    lat(p);
    cmd(CMD_DR, 8'h11, q, 64'({p[16:8], pin_in}));
    lat(q);
    cmd(CMD_IR, 8'h04, 64'(`IR_INTEST), 64'(`IR_CAPTURE));
    cmd(CMD_DR, 8'h11, p, 64'({core_oe, core_out, ~q[7:0]}));
    lat(p);
    foreach (byp_c[i]) begin
      d = 64'(9'($urandom()));
      cmd(CMD_IR, 8'h04, 64'(byp_c[i]), 64'(`IR_CAPTURE));
      cmd(CMD_DR, 8'h09, d, {d[62:0], 1'b0});
      case (byp_c[i])
        `IR_CLAMP: check(64'({pin_oe, pin_out}), 64'(p[16:8]));
        `IR_HIGHZ: check(64'({pin_oe, pin_out}), 64'({1'b0, core_out}));
        `IR_CLAMPZ: check(64'({pin_oe, pin_out}), 64'({1'b0, p[15:8]}));
        default: sys();
      endcase
    end
    cmd(CMD_IR, 8'h04, 64'(`IR_EXTEST), 64'(`IR_CAPTURE));
    // Reset out of test mode, checked before any test clock edge
    fork
      cmd(CMD_RESET, 8'h00, 64'h0, 64'h0);
      begin
        @(negedge tap_if_i.trst_n);
        @(negedge mclk_i);
        sys();
      end
    join
    sys();
    cmd(CMD_DR, 8'h20, 64'($urandom()), 64'(ID));
    end_sim();
  end
endmodule
`default_nettype wire
